// ---- verilog/current_gauge_pwm_encoder.v ----
// Digital back end of a current gauge: filter, average, duty code and PWM out.
// Assumes a one-bit modulator stream and the shutdown pin arrive asynchronously.
`timescale 1ns/1ps
`include "current_gauge_defs.vh"

module current_gauge_pwm_encoder #(
  parameter FULL_SCALE_A = `FULL_SCALE_1A,
  parameter SAMPLE_CYC = `SAMPLE_CYC,
  parameter HALF_STEP_CYC = `HALF_STEP_CYC
) (
  input wire clock,
  input wire rst,
  input wire density_bit,
  input wire low_power_hold_n,
  output reg pwm_out_ff,
  output reg [6:0] measured_current_ff,
  output reg low_power_ff
);

  localparam CNT_W = 24;
  localparam HS_W = 16;
  localparam integer SAMPLE_LAST_I = SAMPLE_CYC - 1;
  localparam integer HS_LAST_I = HALF_STEP_CYC - 1;
  localparam [CNT_W-1:0] SAMPLE_LAST = SAMPLE_LAST_I[CNT_W-1:0];
  localparam [HS_W-1:0] HS_LAST = HS_LAST_I[HS_W-1:0];
  localparam [CNT_W-1:0] SAMPLE_LEN = SAMPLE_LAST + {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [7:0] RAMP_LAST = 8'hff;
  // The code is ratiometric to full scale, so the option only changes how the
  // far side scales a reading; anything but the 2 A option builds as 1 A.
  localparam integer FS_SEL =
    (FULL_SCALE_A == `FULL_SCALE_2A) ? `FULL_SCALE_2A : `FULL_SCALE_1A;

  // Map a signed density sum over one interval onto the 7-bit duty code.
  function [6:0] to_duty;
    input signed [CNT_W:0] sum;
    reg signed [CNT_W+8:0] scaled;
    reg signed [CNT_W+8:0] code;
    begin
      scaled = (sum * $signed({1'b0, `DUTY_SPAN})) / $signed({1'b0, SAMPLE_LEN});
      code = scaled + $signed({1'b0, `DUTY_MID});
      if (code > $signed({1'b0, `DUTY_MAX})) begin
        to_duty = `DUTY_MAX;
      end else if (code < $signed({1'b0, `DUTY_MIN})) begin
        to_duty = `DUTY_MIN;
      end else begin
        to_duty = code[6:0];
      end
    end
  endfunction

  // Number of high taps in the four-tap window.
  function [2:0] ones4;
    input [3:0] taps;
    begin
      ones4 = {2'b00, taps[0]} + {2'b00, taps[1]} + {2'b00, taps[2]} + {2'b00, taps[3]};
    end
  endfunction

  reg bit_s1_ff;
  reg bit_s2_ff;
  reg hold_s1_ff;
  reg hold_s2_ff;
  reg [3:0] fir_ff;
  reg signed [CNT_W:0] acc_ff;
  reg [CNT_W-1:0] smp_ff;
  reg [6:0] duty_pend_ff;
  reg [6:0] duty_ff;
  reg [HS_W-1:0] hs_ff;
  reg [7:0] ramp_ff;
  reg [2:0] tap_cnt;
  reg [1:0] filt_sum;
  reg signed [CNT_W:0] nxt_acc;
  wire run_en;
  wire interval_end;
  wire step_end;
  wire period_end;
  wire [7:0] duty_thresh;

  assign run_en = hold_s2_ff;
  assign interval_end = (smp_ff == SAMPLE_LAST);
  assign step_end = (hs_ff == HS_LAST);
  assign period_end = step_end && (ramp_ff == RAMP_LAST);
  // An odd threshold keeps the output high for one extra half step.
  assign duty_thresh = {duty_ff, 1'b1};

  // Two-stage sync of the modulator stream; the first stage feeds nothing else.
  always @(posedge clock) begin
    if (rst) begin
      bit_s1_ff <= 1'b0;
      bit_s2_ff <= 1'b0;
    end else begin
      bit_s1_ff <= density_bit;
      bit_s2_ff <= bit_s1_ff;
    end
  end

  // Two-stage sync of the shutdown pin. It resets to the pulled-up idle level,
  // so no false shutdown pulse follows reset.
  always @(posedge clock) begin
    if (rst) begin
      hold_s1_ff <= 1'b1;
      hold_s2_ff <= 1'b1;
    end else begin
      hold_s1_ff <= low_power_hold_n;
      hold_s2_ff <= hold_s1_ff;
    end
  end

  // A 4-tap majority smoother: +1 for high density, -1 for low, 0 when split.
  always @* begin
    tap_cnt = ones4(fir_ff);
    filt_sum = 2'b00;
    if (tap_cnt > 3'd2) begin
      filt_sum = 2'b01;
    end else if (tap_cnt < 3'd2) begin
      filt_sum = 2'b11;
    end
    nxt_acc = acc_ff + {{(CNT_W-1){filt_sum[1]}}, filt_sum};
  end

  // Shift register of the last four synchronised stream bits.
  always @(posedge clock) begin
    if (rst || !run_en) begin
      fir_ff <= 4'h0;
    end else begin
      fir_ff <= {fir_ff[2:0], bit_s2_ff};
    end
  end

  // Interval counter; it restarts on every wrap and on wake from shutdown.
  always @(posedge clock) begin
    if (rst || !run_en) begin
      smp_ff <= {CNT_W{1'b0}};
    end else if (interval_end) begin
      smp_ff <= {CNT_W{1'b0}};
    end else begin
      smp_ff <= smp_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // The interval average is boxcar-integrated, so a surge shorter than an
  // interval only moves the code in proportion to its share of the interval.
  always @(posedge clock) begin
    if (rst || !run_en) begin
      acc_ff <= {(CNT_W+1){1'b0}};
    end else if (interval_end) begin
      acc_ff <= {(CNT_W+1){1'b0}};
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // The finished interval's code waits here until the next period starts.
  always @(posedge clock) begin
    if (rst || !run_en) begin
      duty_pend_ff <= `DUTY_MID;
    end else if (interval_end) begin
      duty_pend_ff <= to_duty(nxt_acc);
    end
  end

  // Half-step prescaler: one ramp step every HALF_STEP_CYC clocks.
  always @(posedge clock) begin
    if (rst || !run_en) begin
      hs_ff <= {HS_W{1'b0}};
    end else if (step_end) begin
      hs_ff <= {HS_W{1'b0}};
    end else begin
      hs_ff <= hs_ff + {{(HS_W-1){1'b0}}, 1'b1};
    end
  end

  // Free-running ramp of 256 half steps, one PWM period per wrap.
  always @(posedge clock) begin
    if (rst || !run_en) begin
      ramp_ff <= 8'h00;
    end else if (step_end) begin
      ramp_ff <= ramp_ff + 8'h01;
    end
  end

  // Loading only at the wrap keeps every period whole; a fresh code can
  // therefore wait up to one period before it shows.
  always @(posedge clock) begin
    if (rst || !run_en) begin
      duty_ff <= `DUTY_MID;
    end else if (period_end) begin
      duty_ff <= duty_pend_ff;
    end
  end

  // Ramp compare; the output register adds one clock of lag to both edges.
  always @(posedge clock) begin
    if (rst || !run_en) begin
      pwm_out_ff <= 1'b0;
    end else begin
      pwm_out_ff <= (ramp_ff < duty_thresh);
    end
  end

  // Shutdown flag seen by the far side.
  always @(posedge clock) begin
    if (rst) begin
      low_power_ff <= 1'b0;
    end else begin
      low_power_ff <= !run_en;
    end
  end

  // The reported code follows the pending code, parked at the midpoint 64 in shutdown.
  always @(posedge clock) begin
    if (rst) begin
      measured_current_ff <= `DUTY_MID;
    end else begin
      measured_current_ff <= duty_pend_ff;
    end
  end

endmodule // current_gauge_pwm_encoder

// ---- verilog/current_gauge_defs.vh ----
// Constants for the current gauge PWM encoder: timing, duty scaling and codes.
// Assumes a 40 MHz core clock and a 7-bit duty code of 128 steps.
`ifndef CURRENT_GAUGE_DEFS_VH
`define CURRENT_GAUGE_DEFS_VH

`define CLK_HZ 40000000
`define PWM_FREQ_HZ 160
`define PWM_STEPS 128
`define DUTY_W 7
// Half step of the 128-step period, in clock cycles.
`define HALF_STEP_CYC ((`CLK_HZ / `PWM_FREQ_HZ) / (2 * `PWM_STEPS))
`define STEP_CYC (2 * `HALF_STEP_CYC)
`define SAMPLE_MS 6
`define SAMPLE_CYC ((`CLK_HZ / 1000) * `SAMPLE_MS)
`define SLOT_MS 50
`define SLOT_CYC ((`CLK_HZ / 1000) * `SLOT_MS)
// Duty codes: midpoint 64, limits 95.3% and 4.7% of 128 steps.
`define DUTY_MID 7'h40
`define DUTY_MAX 7'h7a
`define DUTY_MIN 7'h06
// Code span per full scale: 128 / 2.2, rounded, = 58.
`define DUTY_SPAN 7'h3a
`define FULL_SCALE_1A 1
`define FULL_SCALE_2A 2

`endif

// ---- tb/cg_chk_assertions.sv ----
// Checker for the gauge encoder, watching only its ports.
// Assumes a half step of at least one clock and binds to every instance.
`timescale 1ns/1ps
module cg_chk(
  input wire clock,
  input wire rst,
  input wire density_bit,
  input wire low_power_hold_n,
  input wire pwm_out_ff,
  input wire [6:0] measured_current_ff,
  input wire low_power_ff);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_rng; measured_current_ff inside {[7'h06:7'h7a]}; endproperty
  a_rng: assert property (p_rng) else $error("code range");
  property p_lpon; !low_power_hold_n [*4] |-> low_power_ff; endproperty
  a_lpon: assert property (p_lpon) else $error("no sleep");
  property p_lpoff; low_power_hold_n [*4] |-> !low_power_ff; endproperty
  a_lpoff: assert property (p_lpoff) else $error("no wake");
  property p_lpq; low_power_ff |-> !pwm_out_ff; endproperty
  a_lpq: assert property (p_lpq) else $error("pwm in sleep");
  property p_lpc; low_power_ff ##1 low_power_ff |-> measured_current_ff == 7'h40; endproperty
  a_lpc: assert property (p_lpc) else $error("code in sleep");
  property p_hold;
    $changed(measured_current_ff) |=> $stable(measured_current_ff) [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("code hold");
  // Shutdown may cut a level short, so only levels begun in normal mode count.
  property p_hi;
    $rose(pwm_out_ff) && !low_power_ff |=> (pwm_out_ff || low_power_ff) [*8];
  endproperty
  a_hi: assert property (p_hi) else $error("short high");
  property p_lo; $fell(pwm_out_ff) && !low_power_ff |=> !pwm_out_ff [*8]; endproperty
  a_lo: assert property (p_lo) else $error("short low");
  c_max: cover property (measured_current_ff == 7'h7a);
  c_min: cover property (measured_current_ff == 7'h06);
  c_lp: cover property (low_power_ff);
endmodule // cg_chk
bind current_gauge_pwm_encoder cg_chk cg_chk_i(.*);

// ---- tb/duty_meter.sv ----
// Host-side duty meter: high cycles of each finished PWM period.
// Assumes the output changes only on rising clock edges.
`timescale 1ns/1ps
module duty_meter(input wire clock, input wire pwm, output logic [9:0] hi = 0);
  logic [9:0] c = 0;
  logic p = 0;
  // Latching at each rise means a reading covers one whole period, except the first after reset and the one spanning a shutdown.
  always @(posedge clock) begin
    p <= pwm;
    if (pwm && !p) begin
      hi <= c;
      c <= 1;
    end else c <= c + {9'h0, pwm};
  end
endmodule // duty_meter

// ---- tb/tb_current_gauge_pwm_encoder.sv ----
// Bench for the gauge encoder: drives density and shutdown, reads duty.
// Assumes a fast build: 256-cycle intervals and 2-cycle half steps.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t mismatch", $time); end end
module tb_current_gauge_pwm_encoder;
  logic clock = 0, rst = 1, density_bit = 0, low_power_hold_n = 1, alt = 0, dv = 0;
  logic [6:0] measured_current_ff;
  logic pwm_out_ff, low_power_ff;
  logic [9:0] hi;
  int errors = 0, tests_run = 0;
  always #12.5 clock = ~clock;
  always @(posedge clock) density_bit <= alt ? ~density_bit : dv;
  current_gauge_pwm_encoder #(.SAMPLE_CYC(256), .HALF_STEP_CYC(2))
    current_gauge_pwm_encoder_i(.*);
  duty_meter duty_meter_i(.clock(clock), .pwm(pwm_out_ff), .hi(hi));
  task end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Long enough for a pure interval, a period load and one measured period.
  // High time is (2N+1) half steps of two clocks each.
  task settle(input logic a, input logic d, input logic [6:0] n);
    alt <= a;
    dv <= d;
    repeat (3000) @(posedge clock);
    @(negedge clock);
    `CHK(measured_current_ff, n)
    `CHK(hi, {1'b0, n, 2'b10})
  endtask
  task zero_current; settle(1'b1, 1'b0, 7'h40); endtask
  task full_positive; settle(1'b0, 1'b1, 7'h7a); endtask
  task full_negative; settle(1'b0, 1'b0, 7'h06); endtask
  task period_load;
    int i;
    for (i = 0; i < 600 && pwm_out_ff !== 1'b0; i++) @(negedge clock);
    for (i = 0; i < 600 && pwm_out_ff !== 1'b1; i++) @(negedge clock);
    `CHK(pwm_out_ff, 1'b1)
    repeat (25) @(negedge clock);
    `CHK(pwm_out_ff, 1'b1)
    @(negedge clock);
    `CHK(pwm_out_ff, 1'b0)
  endtask
  task shutdown;
    repeat (30) @(posedge clock);
    low_power_hold_n <= 1'b0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    `CHK(low_power_ff, 1'b1)
    `CHK(pwm_out_ff, 1'b0)
    `CHK(measured_current_ff, 7'h40)
    @(posedge clock);
    low_power_hold_n <= 1'b1;
    repeat (6) @(posedge clock);
    @(negedge clock);
    `CHK(low_power_ff, 1'b0)
    `CHK(measured_current_ff, 7'h40)
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    zero_current;
    full_positive;
    full_negative;
    period_load;
    shutdown;
    end_sim;
  end
endmodule // tb_current_gauge_pwm_encoder
